// ===== gio_map.svh
// Overview of operation
// - writes to lamp one or two locations latch the lamp; data 00 on, FF off.
// - coin counters and planet output latch active for 00, inactive for FF.
// - page select latch goes low on data 00 and high on data 01.
// - writing 00 to the axis select location drives axis select low.
// - page select low, first input location reads coin, slam and self-test switches.
// - page select high, axis low, first input location reads trackball position.
// - second input location reads fire, shield, start buttons and vertical blank.
// - work RAM covers sixteen 1024-byte blocks, read returns last written value.
// - addresses 0000 to 0002 are bit-mode locations, not plain storage.
// - two sound chips decoded at 78xx and 70xx, control register at offset F.
// - channel 1 at offsets 0,1 and channel 2 at offsets 2,3 per chip.
// - watchdog inhibit held low stops the watchdog from resetting the system.
`ifndef GIO_MAP_SVH
`define GIO_MAP_SVH
`define GIO_COIN_SW_IN 16'h5000
`define GIO_BUTTON_IN 16'h5001
`define GIO_LAMP_ONE 16'h6C00
`define GIO_LAMP_TWO 16'h6C01
`define GIO_AXIS_SEL 16'h6C02
`define GIO_PAGE_SEL 16'h6C04
`define GIO_COIN_RIGHT 16'h6C05
`define GIO_COIN_LEFT 16'h6C06
`define GIO_PLANET_EN 16'h6C07
`define GIO_LATCH_BASE 13'h0D80
`define GIO_SND_A_PAGE 8'h78
`define GIO_SND_B_PAGE 8'h70
`define GIO_SND_CTRL_OFS 4'hF
`define GIO_BITMODE_TOP 16'h0002
`define GIO_RAM_TOP 16'h3FFF
`define GIO_LATCH_RST 8'hFF
`define GIO_WD_LIMIT 16'hFFFF
`endif

// ===== gio_pkg.sv
package gio_pkg;
  typedef enum logic [1:0] {GIO_IDLE = 2'b00, GIO_WR = 2'b01, GIO_RD = 2'b11} gio_cyc_t;
  typedef logic [7:0] gio_byte_t;
endpackage

// ===== gio_snd_if.sv
`timescale 1ns/1ps
interface gio_snd_if;
  logic wr;
  logic [3:0] ofs;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output wr, ofs, wdata, input rdata);
  modport chip (input wr, ofs, wdata, output rdata);
endinterface

// ===== gio_snd_regs.sv
`timescale 1ns/1ps
`include "gio_map.svh"
module gio_snd_regs
  import gio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus side
  gio_snd_if.chip bus,
  // tone state
  output logic [1:0] tone_on
);
  gio_byte_t regs_q [16];
  gio_byte_t regs_d [16];
  // register next values, one write port
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      regs_d[i] = regs_q[i];
    end
    if (bus.wr)
    begin
      regs_d[bus.ofs] = bus.wdata;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 16; i++)
    begin
      regs_q[i] <= rstn ? regs_d[i] : 8'h00;
    end
  end
  assign bus.rdata = regs_q[bus.ofs];
  // channel audible when control set up and odd offset nonzero
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_ch
      assign tone_on[c] = (regs_q[`GIO_SND_CTRL_OFS] == 8'h03) && (regs_q[2*c+1] != 8'h00);
    end
  endgenerate
endmodule

// ===== gio_top.sv
`timescale 1ns/1ps
`include "gio_map.svh"
module gio_top
  import gio_pkg::*;
#(
  parameter int RAM_WORDS = 16384,
  parameter logic [15:0] WD_LIMIT = `GIO_WD_LIMIT
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // processor bus
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic rvalid,
  // switches and trackball
  input wire logic [4:0] coin_sw,
  input wire logic [5:0] button_sw,
  input wire logic vblank,
  input wire logic [7:0] ball_pos,
  // watchdog
  input wire logic watchdog_inhibit_n,
  input wire logic wd_kick,
  output logic wd_reset,
  // outputs
  output logic lamp_one,
  output logic lamp_two,
  output logic ball_axis_select,
  output logic input_page_select,
  output logic coin_right,
  output logic coin_left,
  output logic planet_en,
  output logic [1:0] snd_a_tone,
  output logic [1:0] snd_b_tone
);
  logic [7:0] ram_q [RAM_WORDS];
  logic [7:0] bitmode_q [3];
  logic [6:0] latch_q, latch_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [15:0] wd_cnt_q, wd_cnt_d;
  logic wd_rst_q, wd_rst_d;
  logic [1:0] snd_a_q, snd_b_q;
  logic sel_a, sel_b, in_ram, in_bit, in_latch;
  logic [1:0] tone_a, tone_b;
  gio_cyc_t cyc;
  gio_snd_if snd_a ();
  gio_snd_if snd_b ();

  // address decode
  assign sel_a = addr[15:8] == `GIO_SND_A_PAGE;
  assign sel_b = addr[15:8] == `GIO_SND_B_PAGE;
  assign in_bit = addr <= `GIO_BITMODE_TOP;
  assign in_ram = (addr <= `GIO_RAM_TOP) && !in_bit;
  assign in_latch = (addr[15:3] == `GIO_LATCH_BASE);
  assign cyc = wr_en ? GIO_WR : (rd_en ? GIO_RD : GIO_IDLE);

  // sound chip ports
  assign snd_a.wr = wr_en && sel_a;
  assign snd_a.ofs = addr[3:0];
  assign snd_a.wdata = wdata;
  assign snd_b.wr = wr_en && sel_b;
  assign snd_b.ofs = addr[3:0];
  assign snd_b.wdata = wdata;

  gio_snd_regs u_snd_a (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .bus(snd_a.chip),
    .tone_on(tone_a)
  );
  gio_snd_regs u_snd_b (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .bus(snd_b.chip),
    .tone_on(tone_b)
  );

  // output latches: bit 7 of data decides, bit 0 for axis and page select, held between writes
  // latch bits skip the unused slot 3, so offsets 4 to 7 land one bit lower
  always_comb
  begin
    latch_d = latch_q;
    if (cyc == GIO_WR && in_latch)
    begin
      case (addr[2:0])
        3'h0: latch_d[0] = wdata[7];
        3'h1: latch_d[1] = wdata[7];
        3'h2: latch_d[2] = wdata[0];
        3'h4: latch_d[3] = wdata[0];
        3'h5: latch_d[4] = wdata[7];
        3'h6: latch_d[5] = wdata[7];
        3'h7: latch_d[6] = wdata[7];
        default: latch_d = latch_q; // slot 3 holds no latch
      endcase
    end
  end

  // read mux, one cycle after the request
  always_comb
  begin
    rvalid_d = (cyc == GIO_RD);
    rdata_d = 8'h00;
    if (cyc == GIO_RD)
    begin
      if (addr == `GIO_COIN_SW_IN)
      begin
        rdata_d = (latch_q[3] && !latch_q[2]) ? ball_pos : {3'h0, coin_sw};
      end
      else if (addr == `GIO_BUTTON_IN)
      begin
        rdata_d = {1'b0, vblank, button_sw};
      end
      else if (in_ram)
      begin
        rdata_d = ram_q[addr[13:0]];
      end
      else if (in_bit)
      begin
        rdata_d = bitmode_q[addr[1:0]] ^ 8'hFF;
      end
      else if (sel_a)
      begin
        rdata_d = snd_a.rdata;
      end
      else if (sel_b)
      begin
        rdata_d = snd_b.rdata;
      end
    end
  end

  // watchdog counter
  always_comb
  begin
    wd_cnt_d = (wd_kick || !watchdog_inhibit_n) ? 16'h0000 : wd_cnt_q + 16'h0001;
    wd_rst_d = watchdog_inhibit_n && (wd_cnt_q == WD_LIMIT);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      latch_q <= 7'h7F;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      wd_cnt_q <= 16'h0000;
      wd_rst_q <= 1'b0;
      snd_a_q <= 2'b00;
      snd_b_q <= 2'b00;
    end
    else
    begin
      latch_q <= latch_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      wd_cnt_q <= wd_cnt_d;
      wd_rst_q <= wd_rst_d;
      snd_a_q <= tone_a;
      snd_b_q <= tone_b;
    end
  end

  // work RAM and bit-mode storage, no reset
  always_ff @(posedge clk_sys)
  begin
    if (cyc == GIO_WR && in_ram)
    begin
      ram_q[addr[13:0]] <= wdata;
    end
    if (cyc == GIO_WR && in_bit)
    begin
      bitmode_q[addr[1:0]] <= wdata;
    end
  end

  assign lamp_one = latch_q[0];
  assign lamp_two = latch_q[1];
  assign ball_axis_select = latch_q[2];
  assign input_page_select = latch_q[3];
  assign coin_right = latch_q[4];
  assign coin_left = latch_q[5];
  assign planet_en = latch_q[6];
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign wd_reset = wd_rst_q;
  assign snd_a_tone = snd_a_q;
  assign snd_b_tone = snd_b_q;

  // checks
  chk_lamp_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_en && addr == `GIO_LAMP_ONE && wdata == 8'h00) |=> !lamp_one)
    else $error("lamp one not on after 00");
  chk_lamp_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_en && addr == `GIO_LAMP_TWO && wdata == 8'hFF) |=> lamp_two)
    else $error("lamp two not off after FF");
  chk_coin_act: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_en && addr == `GIO_COIN_RIGHT && wdata == 8'h00) |=> !coin_right)
    else $error("right counter not active");
  chk_page_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_en && addr == `GIO_PAGE_SEL && wdata == 8'h01) |=> input_page_select)
    else $error("page select not high");
  chk_axis_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_en && addr == `GIO_AXIS_SEL && wdata == 8'h00) |=> !ball_axis_select)
    else $error("axis select not low");
  chk_coin_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_en && !wr_en && addr == `GIO_COIN_SW_IN && !input_page_select) |=> rdata == {3'h0, $past(coin_sw)})
    else $error("coin switch read wrong");
  chk_ball_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_en && !wr_en && addr == `GIO_COIN_SW_IN && input_page_select && !ball_axis_select)
    |=> rdata == $past(ball_pos))
    else $error("trackball read wrong");
  chk_button_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_en && !wr_en && addr == `GIO_BUTTON_IN) |=> rdata[6:0] == {$past(vblank), $past(button_sw)})
    else $error("button read wrong");
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(wr_en && in_latch) |=> $stable(latch_q))
    else $error("latch changed without write");
  chk_wd_inhibit: assert property (@(posedge clk_sys) disable iff (!rstn)
    !watchdog_inhibit_n [*2] |-> !wd_reset)
    else $error("watchdog fired while inhibited");
  chk_ram_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_en && in_ram) ##1 (rd_en && !wr_en && $stable(addr)) |=> rdata == $past(wdata, 2))
    else $error("ram readback wrong");
  cov_ball: cover property (@(posedge clk_sys) disable iff (!rstn)
    rd_en && addr == `GIO_COIN_SW_IN && input_page_select);
  cov_tone: cover property (@(posedge clk_sys) disable iff (!rstn) snd_a_tone[0]);
  cov_lamp: cover property (@(posedge clk_sys) disable iff (!rstn) !lamp_one ##[1:20] lamp_one);
endmodule

// ===== gio_cpu_model.sv
`timescale 1ns/1ps
module gio_cpu_model
  import gio_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // processor bus
  output logic [15:0] addr,
  output gio_byte_t wdata,
  output logic wr_en,
  output logic rd_en
);
  gio_byte_t exp_q[$];
  // bus quiet from time zero
  initial
  begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // one request per cycle; a read notes its expected byte
  task automatic op(input bit w, input logic [15:0] a, input gio_byte_t d);
    @(negedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    if (!w)
    begin
      exp_q.push_back(d);
    end
  endtask
  // drop the strobes and let one cycle pass
  task automatic idle();
    @(negedge clk_sys);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(negedge clk_sys);
  endtask
endmodule

// ===== test_game_io_address_map.sv
`timescale 1ns/1ps
module test_game_io_address_map
  import gio_pkg::*;
();
  localparam logic [15:0] LAT [5] = '{16'h6C00, 16'h6C01, 16'h6C05, 16'h6C06, 16'h6C07};
  localparam int POS [5] = '{6, 5, 2, 1, 0};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr;
  gio_byte_t wdata, rdata, ball_pos, v;
  logic wr_en, rd_en, rvalid, wd_reset, vblank;
  logic wd_kick = 1'b0;
  logic watchdog_inhibit_n = 1'b0;
  logic lamp_one, lamp_two, ball_axis_select, input_page_select, coin_right, coin_left, planet_en;
  logic [4:0] coin_sw;
  logic [5:0] button_sw;
  logic [1:0] snd_a_tone, snd_b_tone;
  logic [15:0] ra [16];
  gio_byte_t rv [16];
  int bad_count = 0;
  int n_checks = 0;
  wire logic [6:0] outs = {lamp_one, lamp_two, ball_axis_select, input_page_select, coin_right, coin_left, planet_en};
  gio_top #(.WD_LIMIT(16'h0010)) i_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .rvalid(rvalid),
    .coin_sw(coin_sw),
    .button_sw(button_sw),
    .vblank(vblank),
    .ball_pos(ball_pos),
    .watchdog_inhibit_n(watchdog_inhibit_n),
    .wd_kick(wd_kick),
    .wd_reset(wd_reset),
    .lamp_one(lamp_one),
    .lamp_two(lamp_two),
    .ball_axis_select(ball_axis_select),
    .input_page_select(input_page_select),
    .coin_right(coin_right),
    .coin_left(coin_left),
    .planet_en(planet_en),
    .snd_a_tone(snd_a_tone),
    .snd_b_tone(snd_b_tone)
  );
  gio_cpu_model u_cpu (
    .clk_sys(clk_sys),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en)
  );
  // free-running clock
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog phase: count resets seen over 48 cycles
  task automatic wd_run(input logic inh, input bit kick, input bit fire);
    int seen = 0;
    watchdog_inhibit_n = inh;
    for (int i = 0; i < 48; i++)
    begin
      @(negedge clk_sys);
      wd_kick = kick && (i % 8 == 0);
      seen += (wd_reset === 1'b1);
    end
    wd_kick = 1'b0;
    chk(8'(seen != 0), 8'(fire));
  endtask
  // read watcher: each answer takes the oldest note
  always @(negedge clk_sys)
  begin
    if (rvalid === 1'b1)
    begin
      if (u_cpu.exp_q.size() > 0)
      begin
        v = u_cpu.exp_q.pop_front();
        chk(rdata, v);
      end
      else
      begin
        chk(8'(u_cpu.exp_q.size()), 8'h01);
      end
    end
  end
  // hang guard
  initial
  begin
    #200us;
    bad_count++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    coin_sw = 5'h00;
    button_sw = 6'h00;
    vblank = 1'b0;
    ball_pos = 8'h00;
    void'($urandom(32));
    repeat (4) @(negedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(8'(outs), 8'h7F);
    for (int i = 0; i < 5; i++)
    begin
      u_cpu.op(1, LAT[i], 8'h00);
      u_cpu.op(1, 16'h6C03, 8'h00);
      u_cpu.idle();
      chk(8'(outs), 8'(7'h7F ^ (7'h01 << POS[i])));
      u_cpu.op(1, LAT[i], 8'hFF);
      u_cpu.idle();
      chk(8'(outs), 8'h7F);
    end
    // mid-run reset sets a held-low latch back to 1
    u_cpu.op(1, 16'h6C00, 8'h00);
    u_cpu.idle();
    chk(8'(outs), 8'h3F);
    rstn <= 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(8'(outs), 8'h7F);
    u_cpu.op(1, 16'h6C04, 8'h00);
    u_cpu.idle();
    chk(8'(outs[4:3]), 8'h02);
    coin_sw = 5'($urandom);
    button_sw = 6'($urandom);
    u_cpu.op(0, 16'h5000, {3'h0, coin_sw});
    for (int i = 0; i < 2; i++)
    begin
      u_cpu.op(0, 16'h5001, {1'b0, vblank, button_sw});
      u_cpu.idle();
      vblank = ~vblank;
    end
    u_cpu.op(1, 16'h6C02, 8'h00);
    u_cpu.op(1, 16'h6C04, 8'h01);
    u_cpu.idle();
    chk(8'(outs[4:3]), 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      ball_pos = 8'($urandom);
      u_cpu.op(0, 16'h5000, ball_pos);
      u_cpu.idle();
    end
    for (int b = 0; b < 16; b++)
    begin
      ra[b] = {b[5:0], 10'h000} + ((b == 0) ? 16'h0003 : (b == 15) ? 16'h03FF : 16'($urandom_range(1020, 4)));
      rv[b] = 8'($urandom);
      u_cpu.op(1, ra[b], rv[b]);
    end
    for (int b = 0; b < 16; b++)
    begin
      u_cpu.op(0, ra[b], rv[b]);
    end
    // write then read the same cell back to back
    u_cpu.op(1, ra[7], ~rv[7]);
    u_cpu.op(0, ra[7], ~rv[7]);
    u_cpu.op(0, 16'h9000, 8'h00);
    for (int a = 0; a < 3; a++)
    begin
      u_cpu.op(1, 16'(a), 8'hA5);
      u_cpu.op(0, 16'(a), 8'h5A);
    end
    u_cpu.idle();
    for (int c = 0; c < 4; c++)
    begin
      ra[0] = c[1] ? 16'h7000 : 16'h7800;
      u_cpu.op(1, ra[0] | 16'h000F, 8'h00);
      u_cpu.op(1, ra[0] | 16'h000F, 8'h03);
      u_cpu.op(1, ra[0] | 16'(c[0] * 2), 8'h55);
      u_cpu.op(1, ra[0] | 16'(c[0] * 2 + 1), 8'hAF);
      u_cpu.op(0, ra[0] | 16'(c[0] * 2), 8'h55);
      u_cpu.idle();
      chk(8'({snd_a_tone, snd_b_tone}), 8'(4'h1 << (c[0] + (c[1] ? 0 : 2))));
      u_cpu.op(1, ra[0] | 16'(c[0] * 2 + 1), 8'h00);
      u_cpu.idle();
      chk(8'({snd_a_tone, snd_b_tone}), 8'h00);
    end
    wd_run(1'b0, 1'b0, 1'b0);
    wd_run(1'b1, 1'b1, 1'b0);
    wd_run(1'b1, 1'b0, 1'b1);
    u_cpu.idle();
    chk(8'(u_cpu.exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
